// ---- dtf_cfg.svh ----
// constants for the debounced toggle fade control
`ifndef DTF_CFG_SVH
`define DTF_CFG_SVH

// clock rate in kHz (125 MHz); also the cycle count of one millisecond
`define DTF_CLK_KHZ     125000
// debounce interval in ms and in clock cycles
`define DTF_DEB_MS      37
`define DTF_DEB_CYC     (`DTF_DEB_MS * `DTF_CLK_KHZ)
`define DTF_DEB_W       23
// ramp time used when a fade select is zero, in us and in cycles
`define DTF_INSTANT_US  70
`define DTF_INSTANT_CYC ((`DTF_INSTANT_US * `DTF_CLK_KHZ) / 1000)
// ramp geometry
`define DTF_STEPS       63
`define DTF_LAST_IDX    62
`define DTF_IDX_W       6
`define DTF_LVL_W       10
// fade select in ms, zero means instant
`define DTF_SEL_W       11
`define DTF_ACC_W       28

`endif

// ---- dtf_debounce.sv ----
// synchroniser and debouncer of the active low toggle input
`timescale 1ns/1ps
`include "dtf_cfg.svh"

module dtf_debounce #(
    parameter int unsigned DEB_CYC = `DTF_DEB_CYC
) (
    input  wire logic mclk_in,    // core clock
    input  wire logic rst_n_in,   // async reset, active low
    input  wire logic clk_en_in,  // freezes state while low
    input  wire logic raw_in,     // pin level, asynchronous
    output logic      level_out,  // debounced level
    output logic      fell_out,   // one-cycle pulse on debounced fall
    output logic      rose_out    // one-cycle pulse on debounced rise
);

    ////////////////////////////////////////////////////////////////////
    localparam dtf_pkg::dtf_deb_t DEB_RST = '{
        s1: 1'b1, s2: 1'b1, last: 1'b1, stable: 1'b1,
        fell: 1'b0, rose: 1'b0, cnt: '0
    };
    localparam logic [`DTF_DEB_W-1:0] CNT_LAST = `DTF_DEB_W'(DEB_CYC - 1);

    dtf_pkg::dtf_deb_t s_q;
    dtf_pkg::dtf_deb_t s_d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d      = s_q;
        s_d.s1   = raw_in;
        s_d.s2   = s_q.s1;
        s_d.last = s_q.s2;
        s_d.fell = 1'b0;
        s_d.rose = 1'b0;
        if (s_q.s2 != s_q.last) begin
            s_d.cnt = '0;
        end else if (s_q.s2 != s_q.stable) begin
            if (s_q.cnt == CNT_LAST) begin
                s_d.stable = s_q.s2;
                s_d.fell   = ~s_q.s2;
                s_d.rose   = s_q.s2;
                s_d.cnt    = '0;
            end else begin
                s_d.cnt = s_q.cnt + `DTF_DEB_W'(1);
            end
        end else begin
            s_d.cnt = '0;
        end
    end

    // undriven pin reads released: every stage resets high
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= DEB_RST;
        end else if (clk_en_in) begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.stable;
    assign fell_out  = s_q.fell;
    assign rose_out  = s_q.rose;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_stable_after_count: assert property (
        $changed(s_q.stable) |-> $past(s_q.cnt) == CNT_LAST
    ) else $error("debounced level changed before interval elapsed");

    a_single_fall_pulse: assert property (
        (s_q.fell && clk_en_in) |=> !s_q.fell
    ) else $error("fall pulse lasted more than one cycle");

    a_release_needed: assert property (
        s_q.fell |-> !s_q.stable ##1 (!s_q.rose)
    ) else $error("release recognised without debounce");

endmodule

// ---- dtf_fade_ctl.sv ----
// debounced toggle with gamma corrected fade in and fade out
`timescale 1ns/1ps
`include "dtf_cfg.svh"


module dtf_fade_ctl #(
    parameter int unsigned DEB_CYC     = `DTF_DEB_CYC,
    parameter int unsigned INSTANT_CYC = `DTF_INSTANT_CYC,
    parameter int unsigned CYC_PER_MS  = `DTF_CLK_KHZ
) (
    input  wire logic                  mclk_in,                 // core clock
    input  wire logic                  rst_n_in,                // async reset, low
    input  wire logic                  clk_en_in,               // freezes state
    input  wire logic                  toggle_n_in,             // toggle pin, low
    input  wire logic                  dim_in,                  // dimming pin
    input  wire logic [`DTF_SEL_W-1:0] fade_in_time_select_in,  // fade-in ms
    input  wire logic [`DTF_SEL_W-1:0] fade_out_time_select_in, // fade-out ms
    output logic      [`DTF_LVL_W-1:0] level_out,               // level, permille
    output logic                       src_on_out,              // source enable
    output logic                       ch_on_out,               // latched state
    output logic                       ramp_active_out          // ramp running
);

    ////////////////////////////////////////////////////////////////////
    localparam logic [`DTF_IDX_W-1:0] LAST_IDX = `DTF_IDX_W'(`DTF_LAST_IDX);
    localparam logic [`DTF_ACC_W-1:0] STEPS    = `DTF_ACC_W'(`DTF_STEPS);

    localparam logic [`DTF_LVL_W-1:0] GAMMA [`DTF_STEPS] = '{
        10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00a, 10'h00c, 10'h010,
        10'h014, 10'h018, 10'h01c, 10'h020, 10'h024, 10'h02a, 10'h030, 10'h036,
        10'h03c, 10'h042, 10'h048, 10'h050, 10'h058, 10'h060, 10'h068, 10'h070,
        10'h078, 10'h082, 10'h08c, 10'h096, 10'h0a0, 10'h0aa, 10'h0b4, 10'h0c2,
        10'h0d0, 10'h0de, 10'h0ec, 10'h0fa, 10'h108, 10'h11a, 10'h12c, 10'h13e,
        10'h150, 10'h162, 10'h174, 10'h18a, 10'h1a0, 10'h1b6, 10'h1cc, 10'h1e2,
        10'h1f8, 10'h216, 10'h234, 10'h252, 10'h270, 10'h28e, 10'h2ac, 10'h2d2,
        10'h2f8, 10'h31e, 10'h344, 10'h36a, 10'h392, 10'h3bc, 10'h3e8
    };

    localparam dtf_pkg::dtf_ctl_t CTL_RST = '{
        st: dtf_pkg::RS_OFF, idx: '0, acc: '0, level: '0,
        src_on: 1'b0, ch_on: 1'b0, ramp: 1'b0, dim_s1: 1'b0, dim_s2: 1'b0
    };

    ////////////////////////////////////////////////////////////////////
    function automatic logic [`DTF_LVL_W-1:0] gamma_of(
        input logic [`DTF_IDX_W-1:0] idx
    );
        gamma_of = GAMMA[idx];
    endfunction

    // whole ramp length in cycles for a select code
    function automatic logic [`DTF_ACC_W-1:0] ramp_cycles(
        input logic [`DTF_SEL_W-1:0] sel
    );
        if (sel == '0) begin
            ramp_cycles = `DTF_ACC_W'(INSTANT_CYC);
        end else begin
            ramp_cycles = `DTF_ACC_W'(sel) * `DTF_ACC_W'(CYC_PER_MS);
        end
    endfunction

    // latched target is on while fading in or at full
    function automatic logic is_on(
        input dtf_pkg::dtf_ramp_t st
    );
        is_on = (st == dtf_pkg::RS_UP) || (st == dtf_pkg::RS_FULL);
    endfunction

    // a ramp runs while fading in either direction
    function automatic logic is_ramping(
        input dtf_pkg::dtf_ramp_t st
    );
        is_ramping = (st == dtf_pkg::RS_UP) || (st == dtf_pkg::RS_DOWN);
    endfunction

    ////////////////////////////////////////////////////////////////////
    dtf_pkg::dtf_ctl_t s_q;
    dtf_pkg::dtf_ctl_t s_d;

    logic                  deb_level;
    logic                  press;
    logic                  tick;
    logic [`DTF_ACC_W-1:0] total;
    logic [`DTF_ACC_W-1:0] acc_n;

    dtf_debounce #(
        .DEB_CYC   (DEB_CYC)
    ) u_deb (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .clk_en_in (clk_en_in),
        .raw_in    (toggle_n_in),
        .level_out (deb_level),
        .fell_out  (press),
        .rose_out  ()
    );

    ////////////////////////////////////////////////////////////////////
    // step timing: add the step count each cycle and step when the sum
    // reaches the ramp length, so 63 intervals fill the fade exactly
    always_comb begin
        s_d        = s_q;
        s_d.dim_s1 = dim_in;
        s_d.dim_s2 = s_q.dim_s1;
        tick       = 1'b0;
        if (s_q.st == dtf_pkg::RS_UP) begin
            total = ramp_cycles(fade_in_time_select_in);
        end else begin
            total = ramp_cycles(fade_out_time_select_in);
        end
        acc_n = s_q.acc + STEPS;
        if (s_q.ramp) begin
            if (acc_n >= total) begin
                tick    = 1'b1;
                s_d.acc = acc_n - total;
            end else begin
                s_d.acc = acc_n;
            end
        end

        unique case (s_q.st)
            dtf_pkg::RS_OFF: begin
                if (press) begin
                    s_d.st  = dtf_pkg::RS_UP;
                    s_d.acc = '0;
                end
            end
            dtf_pkg::RS_UP: begin
                if (press) begin
                    s_d.st  = dtf_pkg::RS_DOWN;
                    s_d.acc = '0;
                end else if (tick) begin
                    if (s_q.idx == LAST_IDX) begin
                        s_d.st = dtf_pkg::RS_FULL;
                    end else begin
                        s_d.idx = s_q.idx + `DTF_IDX_W'(1);
                    end
                end
            end
            dtf_pkg::RS_FULL: begin
                if (press) begin
                    s_d.st  = dtf_pkg::RS_DOWN;
                    s_d.acc = '0;
                end
            end
            dtf_pkg::RS_DOWN: begin
                if (press) begin
                    s_d.st  = dtf_pkg::RS_UP;
                    s_d.acc = '0;
                end else if (tick) begin
                    if (s_q.idx == '0) begin
                        s_d.st = dtf_pkg::RS_OFF;
                    end else begin
                        s_d.idx = s_q.idx - `DTF_IDX_W'(1);
                    end
                end
            end
        endcase

        s_d.ch_on = is_on(s_d.st);
        s_d.ramp  = is_ramping(s_d.st);
        if (s_d.st != dtf_pkg::RS_OFF) begin
            // toggle path owns the source, dimming pin has no say
            s_d.src_on = 1'b1;
            s_d.level  = gamma_of(s_d.idx);
        end else begin
            s_d.src_on = s_q.dim_s2;
            s_d.level  = s_q.dim_s2 ? gamma_of(LAST_IDX) : '0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= CTL_RST;
        end else if (clk_en_in) begin
            s_q <= s_d;
        end
    end

    assign level_out       = s_q.level;
    assign src_on_out      = s_q.src_on;
    assign ch_on_out       = s_q.ch_on;
    assign ramp_active_out = s_q.ramp;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_off_zero_level: assert property (
        (clk_en_in && s_q.st == dtf_pkg::RS_OFF && !press && !s_q.dim_s2)
        |=> (!src_on_out && level_out == '0 && !ch_on_out)
    ) else $error("channel not dark while off");

    a_press_starts_up: assert property (
        (clk_en_in && press && s_q.st == dtf_pkg::RS_OFF)
        |=> (s_q.st == dtf_pkg::RS_UP && ch_on_out && level_out == '0)
    ) else $error("press while off did not start fade-in");

    a_press_fades_down: assert property (
        (clk_en_in && press && s_q.st == dtf_pkg::RS_FULL)
        |=> (s_q.st == dtf_pkg::RS_DOWN && !ch_on_out && ramp_active_out)
    ) else $error("press while on did not start fade-out");

    a_ramp_reverses: assert property (
        (clk_en_in && press && s_q.ramp)
        |=> ($changed(s_q.st) && $stable(s_q.idx) && s_q.acc == '0)
    ) else $error("press during ramp did not reverse it");

    a_up_not_falling: assert property (
        (clk_en_in && s_q.st == dtf_pkg::RS_UP && !press)
        |=> (s_q.idx >= $past(s_q.idx) && level_out >= $past(level_out))
    ) else $error("fade-in level went down");

    a_single_step: assert property (
        $changed(s_q.idx)
        |-> (s_q.idx == $past(s_q.idx) + `DTF_IDX_W'(1)
            || s_q.idx == $past(s_q.idx) - `DTF_IDX_W'(1))
    ) else $error("level index jumped by more than one step");

    a_dim_ignored: assert property (
        (s_q.st != dtf_pkg::RS_OFF)
        |-> (src_on_out && level_out == gamma_of(s_q.idx))
    ) else $error("dimming input affected toggled channel");

    a_dim_passes: assert property (
        (clk_en_in && s_q.st == dtf_pkg::RS_OFF && s_q.dim_s2)
        |=> (src_on_out && (level_out == gamma_of(LAST_IDX) || s_q.ramp))
    ) else $error("high dimming input did not turn the source on");

    a_step_spacing: assert property (
        (clk_en_in && s_q.ramp && $past(tick) && $past(clk_en_in) && !press)
        |-> !tick
    ) else $error("two ramp steps in adjacent cycles");

    // clock enable low holds every register, synchronisers included
    a_enable_freezes: assert property (
        !clk_en_in |=> $stable(s_q)
    ) else $error("state moved while clock enable was low");

    a_down_not_rising: assert property (
        (clk_en_in && s_q.st == dtf_pkg::RS_DOWN && !press)
        |=> (s_q.idx <= $past(s_q.idx)
            && (s_q.st == dtf_pkg::RS_OFF || level_out <= $past(level_out)))
    ) else $error("fade-out level went up");

    a_full_holds_top: assert property (
        (s_q.st == dtf_pkg::RS_FULL)
        |-> (s_q.idx == LAST_IDX && level_out == gamma_of(LAST_IDX)
            && ch_on_out && !ramp_active_out)
    ) else $error("full state not at the top level");

    a_up_reaches_full: assert property (
        (clk_en_in && s_q.st == dtf_pkg::RS_UP && tick && s_q.idx == LAST_IDX && !press)
        |=> (s_q.st == dtf_pkg::RS_FULL && !ramp_active_out)
    ) else $error("fade-in did not settle at full");

    a_down_reaches_off: assert property (
        (clk_en_in && s_q.st == dtf_pkg::RS_DOWN && tick && s_q.idx == '0 && !press)
        |=> (s_q.st == dtf_pkg::RS_OFF && !ch_on_out && !ramp_active_out)
    ) else $error("fade-out did not end in the off state");

    a_off_idx_zero: assert property (
        (s_q.st == dtf_pkg::RS_OFF) |-> (s_q.idx == '0 && !ch_on_out && !ramp_active_out)
    ) else $error("off state left a level index behind");

    a_off_follows_dim: assert property (
        clk_en_in ##1 (s_q.st == dtf_pkg::RS_OFF)
        |-> (src_on_out == $past(s_q.dim_s2)
            && level_out == ($past(s_q.dim_s2) ? gamma_of(LAST_IDX) : `DTF_LVL_W'(0)))
    ) else $error("source did not follow the dimming input while off");

    a_step_moves_level: assert property (
        (clk_en_in && tick && !press && s_q.st == dtf_pkg::RS_UP && s_q.idx != LAST_IDX)
        |=> (level_out > $past(level_out))
    ) else $error("fade-in step left the level unchanged");

    a_press_keeps_level: assert property (
        (clk_en_in && press && s_q.ramp)
        |=> (level_out == $past(level_out))
    ) else $error("reversal made the level jump");

    a_no_step_no_tick: assert property (
        (clk_en_in && !tick) |=> $stable(s_q.idx)
    ) else $error("level index moved without a step tick");

endmodule

// ---- dtf_fade_ctl_tb.sv ----
// self-checking bench of the debounced toggle fade control
`timescale 1ns/1ps
`include "dtf_cfg.svh"

module dtf_fade_ctl_tb;
    localparam int unsigned DEB = 8;
    logic                  mclk_in  = 1'b0;
    logic                  rst_n_in = 1'b0;
    logic                  clk_en   = 1'b1;
    logic                  dim_in   = 1'b0;
    logic                  toggle_n;
    logic [`DTF_SEL_W-1:0] fin_sel  = 11'h002;
    logic [`DTF_SEL_W-1:0] fout_sel = 11'h001;
    logic [`DTF_LVL_W-1:0] level;
    logic                  src_on;
    logic                  ch_on;
    logic                  ramp;
    int                    fail_count   = 0;
    int                    total_checks = 0;
    int                    cyc          = 0;
    int                    n;
    int                    s;

    always #4 mclk_in = ~mclk_in;

    dtf_switch_model u_dtf_switch_model (
        .mclk_in      (mclk_in),
        .toggle_n_out (toggle_n)
    );

    dtf_fade_ctl #(.DEB_CYC(DEB), .INSTANT_CYC(126), .CYC_PER_MS(128)) u_dtf_fade_ctl (
        .mclk_in                 (mclk_in),
        .rst_n_in                (rst_n_in),
        .clk_en_in               (clk_en),
        .toggle_n_in             (toggle_n),
        .dim_in                  (dim_in),
        .fade_in_time_select_in  (fin_sel),
        .fade_out_time_select_in (fout_sel),
        .level_out               (level),
        .src_on_out              (src_on),
        .ch_on_out               (ch_on),
        .ramp_active_out         (ramp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // cycles until the latched state reaches exp
    task automatic wait_ch(input logic exp, output int k);
        k = 0;
        while (ch_on !== exp && k < 200) begin
            @(negedge mclk_in);
            k++;
        end
    endtask

    // length of the running ramp and the number of level changes in it
    task automatic ramp_len(output int k, output int st);
        logic [`DTF_LVL_W-1:0] prev;
        k = 0;
        st = 0;
        prev = level;
        while (ramp === 1'b1 && k < 2000) begin
            @(negedge mclk_in);
            k++;
            if (level !== prev) st++;
            prev = level;
        end
    endtask

    function automatic logic [15:0] in_win(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({src_on, ch_on, ramp}, 16'h0000);
        check(level, 16'h0000);
    endtask

    task automatic t_dim_off();
        dim_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        check(src_on, 16'h0000);
        @(negedge mclk_in);
        check(src_on, 16'h0001);
        check(level, 16'h03e8);
        dim_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        check(src_on, 16'h0000);
    endtask

    task automatic t_fade_in();
        u_dtf_switch_model.move(1'b1);
        wait_ch(1'b1, n);
        check(in_win(n, DEB, DEB + 6), 16'h0001);
        check({src_on, ramp}, 16'h0003);
        check(level, 16'h0000);
        ramp_len(n, s);
        check(s, 16'h003e);
        check(in_win(n, 254, 259), 16'h0001);
        check(level, 16'h03e8);
        u_dtf_switch_model.move(1'b0);
        repeat (DEB + 8) @(negedge mclk_in);
        check({ch_on, ramp}, 16'h0002);
    endtask

    task automatic t_dim_ignored();
        dim_in = 1'b0;
        repeat (5) @(negedge mclk_in);
        check({src_on, level}, 16'h07e8);
        dim_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        check({src_on, level}, 16'h07e8);
    endtask

    task automatic t_instant_off();
        fout_sel = 11'h000;
        u_dtf_switch_model.move(1'b1);
        wait_ch(1'b0, n);
        check(in_win(n, DEB, DEB + 6), 16'h0001);
        check(ramp, 16'h0001);
        ramp_len(n, s);
        check(in_win(n, 123, 129), 16'h0001);
        dim_in = 1'b0;
        u_dtf_switch_model.move(1'b0);
        repeat (DEB + 8) @(negedge mclk_in);
        check({src_on, ch_on, level}, 16'h0000);
        fout_sel = 11'h001;
    endtask

    task automatic t_interrupt();
        u_dtf_switch_model.move(1'b1);
        wait_ch(1'b1, n);
        repeat (60) @(negedge mclk_in);
        u_dtf_switch_model.move(1'b0);
        repeat (DEB + 6) @(negedge mclk_in);
        u_dtf_switch_model.move(1'b1);
        wait_ch(1'b0, n);
        check({ch_on, ramp}, 16'h0001);
        check(in_win(level, 1, 999), 16'h0001);
        u_dtf_switch_model.move(1'b0);
        repeat (DEB + 6) @(negedge mclk_in);
        u_dtf_switch_model.move(1'b1);
        wait_ch(1'b1, n);
        check({ch_on, ramp}, 16'h0003);
        ramp_len(n, s);
        check(level, 16'h03e8);
        u_dtf_switch_model.move(1'b0);
    endtask

    task automatic t_freeze_reset();
        logic [`DTF_LVL_W-1:0] held;
        repeat (DEB + 6) @(negedge mclk_in);
        u_dtf_switch_model.move(1'b1);
        wait_ch(1'b0, n);
        repeat (20) @(negedge mclk_in);
        held = level;
        clk_en = 1'b0;
        repeat (40) @(negedge mclk_in);
        check(level, held);
        check({ch_on, ramp}, 16'h0001);
        clk_en = 1'b1;
        ramp_len(n, s);
        check({src_on, ch_on, ramp, level}, 16'h0000);
        u_dtf_switch_model.move(1'b0);
        repeat (DEB + 6) @(negedge mclk_in);
        fin_sel = 11'h000;
        u_dtf_switch_model.move(1'b1);
        wait_ch(1'b1, n);
        ramp_len(n, s);
        check(in_win(n, 123, 129), 16'h0001);
        check(level, 16'h03e8);
        u_dtf_switch_model.move(1'b0);
        repeat (DEB + 6) @(negedge mclk_in);
        rst_n_in = 1'b0;
        @(negedge mclk_in);
        check({src_on, ch_on, ramp, level}, 16'h0000);
        rst_n_in = 1'b1;
        @(negedge mclk_in);
        t_reset();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge mclk_in);
        t_reset();
        rst_n_in = 1'b1;
        @(negedge mclk_in);
        t_reset();
        t_dim_off();
        t_fade_in();
        t_dim_ignored();
        t_instant_off();
        t_interrupt();
        t_freeze_reset();
        repeat (20) @(negedge mclk_in);
        end_sim();
    end
endmodule

// ---- dtf_pkg.sv ----
// types of the debounced toggle fade control
`include "dtf_cfg.svh"

package dtf_pkg;

    typedef enum logic [1:0] {
        RS_OFF,
        RS_UP,
        RS_FULL,
        RS_DOWN
    } dtf_ramp_t;

    typedef struct packed {
        logic                   s1;
        logic                   s2;
        logic                   last;
        logic                   stable;
        logic                   fell;
        logic                   rose;
        logic [`DTF_DEB_W-1:0]  cnt;
    } dtf_deb_t;

    typedef struct packed {
        dtf_ramp_t              st;
        logic [`DTF_IDX_W-1:0]  idx;
        logic [`DTF_ACC_W-1:0]  acc;
        logic [`DTF_LVL_W-1:0]  level;
        logic                   src_on;
        logic                   ch_on;
        logic                   ramp;
        logic                   dim_s1;
        logic                   dim_s2;
    } dtf_ctl_t;

endpackage

// ---- dtf_switch_model.sv ----
// momentary contact switch model driving the toggle pin
`timescale 1ns/1ps

module dtf_switch_model #(
    parameter int unsigned BOUNCE_CYC = 3
) (
    input  wire logic mclk_in,      // bench clock
    output logic      toggle_n_out  // switch line to the toggle pin
);
    logic closed_q = 1'b0;

    // an open contact leaves the line to the pull-up
    assign toggle_n_out = closed_q ? 1'b0 : 1'b1;

    // each transition chatters with gaps shorter than the debounce window
    task automatic move(input logic close);
        for (int i = 0; i < 5; i++) begin
            repeat (BOUNCE_CYC) @(negedge mclk_in);
            closed_q = (i % 2 == 0) ? close : !close;
        end
    endtask
endmodule
